/* rtl/card_regs_map.svh */
/*
 * Register offsets, field positions and reset values of the card register
 * bank. Assumes inclusion by bare name from the design file.
 */
`ifndef CARD_REGS_MAP_SVH
`define CARD_REGS_MAP_SVH

`define ADDR_W 16
`define DATA_W 8
`define OFF_BOARD_CODE 16'h0000
`define OFF_EXT_HIGH 16'h0002
`define OFF_EXT_MIDDLE 16'h0003
`define OFF_EXT_LOW 16'h0004
`define OFF_FAB_REV 16'h0005
`define OFF_ASSY_REV 16'h0006
`define OFF_FW_REV 16'h0007
`define OFF_CLK1544 16'h0011
`define OFF_CLK2048 16'h0012
`define OFF_PAIR_A 16'h0013
`define OFF_PAIR_B 16'h0014
`define OFF_LEVELS 16'h0015
`define LOCAL_LAST 16'h0015
`define XCVR_FIRST 16'h1000
`define XCVR_LAST 16'h10FF
`define CTRL_W 4
`define RST_CLK1544 4'hF
`define RST_CLK2048 4'h3
`define RST_PAIR_A 4'hF
`define RST_PAIR_B 4'h3
`define RST_LEVELS 4'h6
`define SW_MASTER 3
`define SW_TX_CLK 2
`define SW_RX_SYS 1
`define SW_TX_SYS 0

`endif

/* rtl/card_regs_pkg.sv */
/*
 * Types shared by the card register bank. Assumes nothing else.
 */
package card_regs_pkg;
    typedef logic [3:0] ctrl_nib_t;
    typedef logic [7:0] reg_byte_t;
endpackage

/* rtl/board_id_and_clock_routing_regs.sv */
/*
 * Card logic register bank: identification, revision and switch routing
 * registers, plus steering of the transceiver window.
 * Assumes a synchronous host strobe on SYS_CLK_I; the window base is
 * already stripped by the host, so only the offset arrives here.
 */
`timescale 1ns/1ns
`include "card_regs_map.svh"

module board_id_and_clock_routing_regs #(
    parameter logic [7:0] BOARD_CODE = 8'h01,    // Arbitrary value
    parameter logic [3:0] EXT_HIGH = 4'h1,       // Arbitrary value
    parameter logic [3:0] EXT_MIDDLE = 4'h2,     // Arbitrary value
    parameter logic [3:0] EXT_LOW = 4'h3,        // Arbitrary value
    parameter logic [7:0] FAB_REV = 8'h01,
    parameter logic [7:0] ASSY_REV = 8'h01,
    parameter logic [7:0] FW_REV = 8'h01
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    // Host access, offset within the card window
    input wire logic ACC_I,
    input wire logic WR_I,
    input wire logic [`ADDR_W-1:0] ADDR_I,
    input wire logic [`DATA_W-1:0] WDATA_I,
    output logic [`DATA_W-1:0] RDATA_O,
    output logic RVALID_O,
    // Transceiver window steering
    output logic XCVR_SEL_O,
    output logic [7:0] XCVR_ADDR_O,
    // Switch bank and pin level controls, zero closes a switch
    output logic [`CTRL_W-1:0] CLK1544_SW_O,
    output logic [`CTRL_W-1:0] CLK2048_SW_O,
    output logic [`CTRL_W-1:0] PAIR_A_SW_O,
    output logic [`CTRL_W-1:0] PAIR_B_SW_O,
    output logic [`CTRL_W-1:0] PIN_LEVEL_O
);

    card_regs_pkg::ctrl_nib_t clock_1544_routing;
    card_regs_pkg::ctrl_nib_t clock_2048_routing;
    card_regs_pkg::ctrl_nib_t pin_pair_routing_a;
    card_regs_pkg::ctrl_nib_t pin_pair_routing_b;
    card_regs_pkg::ctrl_nib_t pin_level_control;
    card_regs_pkg::reg_byte_t next_rdata;

    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Offsets only, the host adds its own base
    wire logic in_local = (ADDR_I <= `LOCAL_LAST);
    wire logic in_xcvr = (ADDR_I >= `XCVR_FIRST) &&
                         (ADDR_I <= `XCVR_LAST);
    wire logic wr_local = ACC_I && WR_I && in_local;
    // Only control offsets accept writes
    wire logic wr_1544 = wr_local && hit(ADDR_I, `OFF_CLK1544);
    wire logic wr_2048 = wr_local && hit(ADDR_I, `OFF_CLK2048);
    wire logic wr_pa = wr_local && hit(ADDR_I, `OFF_PAIR_A);
    wire logic wr_pb = wr_local && hit(ADDR_I, `OFF_PAIR_B);
    wire logic wr_lv = wr_local && hit(ADDR_I, `OFF_LEVELS);

    // Read mux, upper bits zero on nibble registers, gaps read zero
    always_comb begin
        case (ADDR_I)
            `OFF_BOARD_CODE: next_rdata = BOARD_CODE;
            `OFF_EXT_HIGH: next_rdata = {4'h0, EXT_HIGH};
            `OFF_EXT_MIDDLE: next_rdata = {4'h0, EXT_MIDDLE};
            `OFF_EXT_LOW: next_rdata = {4'h0, EXT_LOW};
            `OFF_FAB_REV: next_rdata = FAB_REV;
            `OFF_ASSY_REV: next_rdata = ASSY_REV;
            `OFF_FW_REV: next_rdata = FW_REV;
            `OFF_CLK1544: next_rdata = {4'h0, clock_1544_routing};
            `OFF_CLK2048: next_rdata = {4'h0, clock_2048_routing};
            `OFF_PAIR_A: next_rdata = {4'h0, pin_pair_routing_a};
            `OFF_PAIR_B: next_rdata = {4'h0, pin_pair_routing_b};
            `OFF_LEVELS: next_rdata = {4'h0, pin_level_control};
            default: next_rdata = 8'h00;
        endcase
    end

    // 1544 clock and pair A routing reset open, 2048 clock and pair B reset with bits 3:2 closed; contention is software's problem
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            clock_1544_routing <= `RST_CLK1544;
            clock_2048_routing <= `RST_CLK2048;
            pin_pair_routing_a <= `RST_PAIR_A;
            pin_pair_routing_b <= `RST_PAIR_B;
            pin_level_control <= `RST_LEVELS;
        end else begin
            if (wr_1544) clock_1544_routing <= WDATA_I[3:0];
            if (wr_2048) clock_2048_routing <= WDATA_I[3:0];
            if (wr_pa) pin_pair_routing_a <= WDATA_I[3:0];
            if (wr_pb) pin_pair_routing_b <= WDATA_I[3:0];
            if (wr_lv) pin_level_control <= WDATA_I[3:0];
        end
    end

    // Switch and level outputs registered once more
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CLK1544_SW_O <= `RST_CLK1544;
            CLK2048_SW_O <= `RST_CLK2048;
            PAIR_A_SW_O <= `RST_PAIR_A;
            PAIR_B_SW_O <= `RST_PAIR_B;
            PIN_LEVEL_O <= `RST_LEVELS;
        end else begin
            CLK1544_SW_O <= clock_1544_routing;
            CLK2048_SW_O <= clock_2048_routing;
            PAIR_A_SW_O <= pin_pair_routing_a;
            PAIR_B_SW_O <= pin_pair_routing_b;
            PIN_LEVEL_O <= pin_level_control;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= 8'h00;
            RVALID_O <= 1'b0;
            XCVR_SEL_O <= 1'b0;
            XCVR_ADDR_O <= 8'h00;
        end else begin
            RVALID_O <= ACC_I && !WR_I && in_local;
            RDATA_O <= (ACC_I && !WR_I && in_local) ? next_rdata : 8'h00;
            XCVR_SEL_O <= ACC_I && in_xcvr;
            XCVR_ADDR_O <= ADDR_I[7:0];
        end
    end

endmodule // board_id_and_clock_routing_regs

/* bench/board_regs_sva.sv */
/* Port checker for the card register bank.
   Assumes the bind below onto the bank. */
`timescale 1ns/1ns
module board_regs_sva (
    input wire logic SYS_CLK_I, ARST_N_I, ACC_I, WR_I, RVALID_O, XCVR_SEL_O,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] WDATA_I, RDATA_O, XCVR_ADDR_O,
    input wire logic [3:0] CLK1544_SW_O, CLK2048_SW_O, PAIR_A_SW_O,
    input wire logic [3:0] PAIR_B_SW_O, PIN_LEVEL_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    wire rd = ACC_I && !WR_I;
    wire wr = ACC_I && WR_I;
    rd_answer_a: assert property (rd && ADDR_I < 16'h0016 |=> RVALID_O)
        else $error("read unanswered");
    no_answer_a: assert property (!rd || ADDR_I > 16'h0015 |=> !RVALID_O)
        else $error("stray answer");
    steer_a: assert property (ACC_I && ADDR_I[15:8] == 8'h10 |=>
        XCVR_SEL_O && XCVR_ADDR_O == $past(ADDR_I[7:0])) else $error("no steer");
    clk_write_a: assert property (wr && ADDR_I == 16'h0011 |=> ##1
        CLK1544_SW_O == $past(WDATA_I[3:0], 2)) else $error("stale switch");
    level_write_a: assert property (wr && ADDR_I == 16'h0015 |=> ##1
        PIN_LEVEL_O == $past(WDATA_I[3:0], 2)) else $error("stale level");
    switch_cause_a: assert property ($changed(CLK2048_SW_O) |->
        $past(wr && ADDR_I == 16'h0012, 2)) else $error("unasked switch");
    upper_zero_a: assert property (rd && ADDR_I[15:4] == 12'h001 |=>
        RDATA_O[7:4] == 4'h0) else $error("upper bits set");
    reset_open_a: assert property ($rose(ARST_N_I) |->
        CLK1544_SW_O == 4'hF) else $error("switch not open");
    rd_c: cover property (RVALID_O);
    steer_c: cover property (XCVR_SEL_O);
    level_c: cover property ($changed(PIN_LEVEL_O));
endmodule // board_regs_sva

bind board_id_and_clock_routing_regs board_regs_sva chk (.*);

/* bench/host_model.sv */
/* Host model: one strobed access a cycle on window offsets.
   Assumes the window base is stripped before the bank. */
`timescale 1ns/1ns
module host_model (
    input wire logic SYS_CLK_I,
    output logic ACC_I,
    output logic WR_I,
    output logic [15:0] ADDR_I,
    output logic [7:0] WDATA_I
);
    initial {ACC_I, WR_I, ADDR_I, WDATA_I} = 26'h0;
    // Offsets only, base placed per board and slot
    task automatic go(input logic a, w, input logic [15:0] ad,
                      input logic [7:0] d);
        @(posedge SYS_CLK_I);
        ACC_I <= a;
        WR_I <= w;
        // Idle address and data lines never keep the old value
        ADDR_I <= a ? ad : ~ADDR_I;
        WDATA_I <= a ? d : ~WDATA_I;
    endtask
endmodule // host_model

/* bench/tb_board_id_and_clock_routing_regs.sv */
/* Self-checking bench for the card register bank.
   Assumes host model and checker are compiled first. */
`timescale 1ns/1ns
module tb_board_id_and_clock_routing_regs;
    logic SYS_CLK_I = 1'b0;
    logic ARST_N_I = 1'b0;
    wire ACC_I, WR_I, RVALID_O, XCVR_SEL_O;
    wire [15:0] ADDR_I;
    wire [7:0] WDATA_I, RDATA_O, XCVR_ADDR_O;
    wire [3:0] CLK1544_SW_O, CLK2048_SW_O, PAIR_A_SW_O, PAIR_B_SW_O, PIN_LEVEL_O;
    wire [19:0] sw = {CLK1544_SW_O, CLK2048_SW_O, PAIR_A_SW_O, PAIR_B_SW_O,
                      PIN_LEVEL_O};
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] q[$];
    logic [7:0] xq[$];
    logic [7:0] x;
    logic [3:0] d[5];
    host_model h (.*);
    board_id_and_clock_routing_regs dut (.*);
    initial forever #50 SYS_CLK_I = ~SYS_CLK_I;
    task automatic check(input string n, input logic [19:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        q.push_back(e);
        h.go(1'b1, 1'b0, a, 8'h00);
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(negedge SYS_CLK_I) if (RVALID_O !== 1'b0) begin
        if (q.size() == 0) check("answer", 20'h0, 20'h1);
        else check("read data", q.pop_front(), RDATA_O);
    end
    // Steering pulse carries the low offset byte to the transceiver
    always @(negedge SYS_CLK_I) if (XCVR_SEL_O !== 1'b0) begin
        if (xq.size() == 0) check("steer", 20'h0, 20'h1);
        else check("steer addr", xq.pop_front(), XCVR_ADDR_O);
    end
    initial begin
        repeat (5000) @(posedge SYS_CLK_I);
        n_fail++;
        close_out();
    end
    initial begin
        void'($urandom(32'h299D));
        repeat (2) begin
            @(posedge SYS_CLK_I);
            ARST_N_I <= 1'b0;
            repeat (12) @(posedge SYS_CLK_I);
            ARST_N_I <= 1'b1;
            @(negedge SYS_CLK_I);
            check("reset", 20'hF3F36, sw);
            for (int i = 0; i < 8; i++) rd(16'(i), (i == 1) ? 8'h00 :
                (i == 0 || i > 4) ? 8'h01 : 8'(i - 1));
            h.go(1'b1, 1'b1, 16'h0000, 8'($urandom));
            rd(16'h0000, 8'h01);
            for (int i = 0; i < 5; i++) d[i] = 4'($urandom);
            d[1] = d[1] | ~d[0]; // No pin closed on both clocks
            for (int i = 0; i < 5; i++)
                h.go(1'b1, 1'b1, 16'h0011 + 16'(i), {4'($urandom), d[i]});
            for (int i = 0; i < 5; i++) rd(16'h0011 + 16'(i), {4'h0, d[i]});
            x = 8'($urandom);
            xq.push_back(x);
            h.go(1'b1, 1'b0, {8'h10, x}, 8'h00);
            h.go(1'b1, 1'b0, 16'h0016, 8'h00);
            h.go(1'b0, 1'b0, 16'h0000, 8'h00);
            @(negedge SYS_CLK_I);
            check("switches", {d[0], d[1], d[2], d[3], d[4]}, sw);
        end
        check("pending", 20'h0, 20'(q.size()));
        check("pending steer", 20'h0, 20'(xq.size()));
        close_out();
    end
endmodule // tb_board_id_and_clock_routing_regs
